// >>> verilog/rjl_defs.vh
// constants for the relative branch and register load execution block
`ifndef RJL_DEFS_VH
`define RJL_DEFS_VH

// branch opcode: condition in upper nibble, fixed lower nibble
`define RJL_BR_LOW_NIBBLE   4'hB

// register load opcodes: register, pointer, immediate and indexed forms
`define RJL_LOAD_R_R        8'hE4
`define RJL_LOAD_R_PTR      8'hE5
`define RJL_LOAD_R_IMM      8'hE6
`define RJL_LOAD_PTR_R      8'hF5
`define RJL_LOAD_R_IDX      8'hC7
`define RJL_LOAD_IDX_R      8'hD7

// operand byte upper nibble that selects a working register
`define RJL_WREG_ESCAPE     4'hE

// register file location of the interrupt mask (251 decimal)
`define RJL_INT_MASK_ADDR   8'hFB
`define RJL_INT_MASK_RST    8'h00

// branch condition codes
`define RJL_COND_NEVER      4'h0
`define RJL_COND_LT         4'h1
`define RJL_COND_LE         4'h2
`define RJL_COND_ULE        4'h3
`define RJL_COND_OV         4'h4
`define RJL_COND_MI         4'h5
`define RJL_COND_Z          4'h6
`define RJL_COND_C          4'h7
`define RJL_COND_ALWAYS     4'h8
`define RJL_COND_GE         4'h9
`define RJL_COND_GT         4'hA
`define RJL_COND_UGT        4'hB
`define RJL_COND_NOV        4'hC
`define RJL_COND_PL         4'hD
`define RJL_COND_NZ         4'hE
`define RJL_COND_NC         4'hF

`endif

// >>> verilog/rjl_cond_eval.v
// branch condition evaluator from the carry, zero, sign and overflow flags
`timescale 1ns/100ps
`include "rjl_defs.vh"

module rjl_cond_eval (
    input  wire [3:0] i_cond,
    input  wire       i_flag_c,
    input  wire       i_flag_z,
    input  wire       i_flag_s,
    input  wire       i_flag_v,
    output reg        o_true
);

    always @* begin
        case (i_cond)
            `RJL_COND_NEVER:  o_true = 1'b0;
            `RJL_COND_LT:     o_true = i_flag_s ^ i_flag_v;
            `RJL_COND_LE:     o_true = i_flag_z | (i_flag_s ^ i_flag_v);
            `RJL_COND_ULE:    o_true = i_flag_c | i_flag_z;
            `RJL_COND_OV:     o_true = i_flag_v;
            `RJL_COND_MI:     o_true = i_flag_s;
            `RJL_COND_Z:      o_true = i_flag_z;
            `RJL_COND_C:      o_true = i_flag_c;
            `RJL_COND_ALWAYS: o_true = 1'b1;
            `RJL_COND_GE:     o_true = ~(i_flag_s ^ i_flag_v);
            `RJL_COND_GT:     o_true = ~(i_flag_z | (i_flag_s ^ i_flag_v));
            `RJL_COND_UGT:    o_true = ~(i_flag_c | i_flag_z);
            `RJL_COND_NOV:    o_true = ~i_flag_v;
            `RJL_COND_PL:     o_true = ~i_flag_s;
            `RJL_COND_NZ:     o_true = ~i_flag_z;
            `RJL_COND_NC:     o_true = ~i_flag_c;
            default:        o_true = 1'b0;
        endcase
    end

endmodule // rjl_cond_eval

// >>> verilog/rjl_exec.v
// relative branch and register load execution unit
`timescale 1ns/100ps
`include "rjl_defs.vh"

// Overview of operation
// - taken branch adds displacement to PC; condition in opcode top nibble.
// - branch not taken leaves PC at the next sequential instruction.
// - displacement is a signed byte, +127 forward to -128 backward.
// - branch base is the address after the whole branch instruction.
// - blank condition code is always true, so the branch is always taken.
// - load copies source to destination; source and flags unchanged.
// - restricted load form accepts only a full 8-bit destination register address.
// - operand upper nibble escape selects a working register by low nibble.
// - indexed address is 8-bit base plus the selected working register.
// - location 251 is the interrupt mask; loads there update it.
module rjl_exec (
    input  wire        i_ref_clk,
    input  wire        i_nrst,
    input  wire        i_instr_valid,
    input  wire [7:0]  i_opcode,
    input  wire [7:0]  i_operand1,
    input  wire [7:0]  i_operand2,
    input  wire [15:0] i_pc_next,
    input  wire        i_flag_c,
    input  wire        i_flag_z,
    input  wire        i_flag_s,
    input  wire        i_flag_v,
    input  wire [7:0]  i_rp,
    input  wire [7:0]  i_rf_rd_data,
    output wire        o_busy,
    output wire        o_done,
    output wire        o_bad_op,
    output wire        o_pc_load,
    output wire [15:0] o_pc_value,
    output wire        o_branch_taken,
    output wire        o_rf_rd_en,
    output wire [7:0]  o_rf_rd_addr,
    output wire        o_rf_wr_en,
    output wire [7:0]  o_rf_wr_addr,
    output wire [7:0]  o_rf_wr_data,
    output wire [7:0]  o_int_mask
);

    localparam [5:0] ST_IDLE = 6'b000001;
    localparam [5:0] ST_RD1  = 6'b000010;
    localparam [5:0] ST_G1   = 6'b000100;
    localparam [5:0] ST_RD2  = 6'b001000;
    localparam [5:0] ST_G2   = 6'b010000;
    localparam [5:0] ST_WR   = 6'b100000;

    // operand byte to register file address; short form only when allowed
    function [7:0] reg_addr;
        input [7:0] b;
        input [7:0] rp;
        input       allow_short;
        begin
            if (allow_short && (b[7:4] == `RJL_WREG_ESCAPE)) begin
                reg_addr = {rp[7:4], b[3:0]};
            end else begin
                reg_addr = b;
            end
        end
    endfunction

    // working register from a bare 4-bit selector
    function [7:0] wreg;
        input [3:0] n;
        input [7:0] rp;
        begin
            wreg = {rp[7:4], n};
        end
    endfunction

    reg  [5:0]  state_r;
    reg         busy_r;
    reg         done_r;
    reg         bad_op_r;
    reg         pc_load_r;
    reg  [15:0] pc_value_r;
    reg         taken_r;
    reg         rd_en_r;
    reg  [7:0]  rd_addr_r;
    reg         wr_en_r;
    reg  [7:0]  wr_addr_r;
    reg  [7:0]  wr_data_r;
    reg  [7:0]  int_mask_r;
    reg  [7:0]  dst_r;
    reg  [7:0]  src_r;
    reg  [7:0]  base_r;
    reg         ptr_to_dst_r;

    wire        cond_true;
    wire        start;
    wire        is_branch;
    wire [15:0] disp_ext;
    wire [15:0] br_target;
    wire [7:0]  eff_addr;

    rjl_cond_eval u_cond (
        .i_cond   (i_opcode[7:4]),
        .i_flag_c (i_flag_c),
        .i_flag_z (i_flag_z),
        .i_flag_s (i_flag_s),
        .i_flag_v (i_flag_v),
        .o_true   (cond_true)
    );

    assign start     = i_instr_valid & state_r[0];
    assign is_branch = (i_opcode[3:0] == `RJL_BR_LOW_NIBBLE);
    // sign extension keeps the reach at +127 / -128
    assign disp_ext  = {{8{i_operand1[7]}}, i_operand1};
    // base is the address after the two-byte branch, not the opcode
    assign br_target = i_pc_next + disp_ext;
    // base_r is zero for plain indirect, so one adder serves both forms
    assign eff_addr  = i_rf_rd_data + base_r;

    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r      <= ST_IDLE;
            busy_r       <= 1'b0;
            done_r       <= 1'b0;
            bad_op_r     <= 1'b0;
            pc_load_r    <= 1'b0;
            pc_value_r   <= 16'h0000;
            taken_r      <= 1'b0;
            rd_en_r      <= 1'b0;
            rd_addr_r    <= 8'h00;
            wr_en_r      <= 1'b0;
            wr_addr_r    <= 8'h00;
            wr_data_r    <= 8'h00;
            int_mask_r   <= `RJL_INT_MASK_RST;
            dst_r        <= 8'h00;
            src_r        <= 8'h00;
            base_r       <= 8'h00;
            ptr_to_dst_r <= 1'b0;
        end else begin
            done_r    <= 1'b0;
            bad_op_r  <= 1'b0;
            pc_load_r <= 1'b0;
            rd_en_r   <= 1'b0;
            wr_en_r   <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    base_r <= 8'h00;
                    if (start && is_branch) begin
                        pc_load_r <= 1'b1;
                        done_r    <= 1'b1;
                        taken_r   <= cond_true;
                        if (cond_true) begin
                            pc_value_r <= br_target;
                        end else begin
                            pc_value_r <= i_pc_next;
                        end
                    end else if (start) begin
                        busy_r <= 1'b1;
                        case (i_opcode)
                            `RJL_LOAD_R_R: begin
                                dst_r     <= reg_addr(i_operand1, i_rp, 1'b1);
                                rd_addr_r <= reg_addr(i_operand2, i_rp, 1'b1);
                                rd_en_r   <= 1'b1;
                                state_r   <= ST_RD2;
                            end
                            `RJL_LOAD_R_PTR: begin
                                // destination never takes the short form
                                dst_r        <= reg_addr(i_operand1, i_rp,
                                                         1'b0);
                                rd_addr_r    <= reg_addr(i_operand2, i_rp,
                                                         1'b1);
                                ptr_to_dst_r <= 1'b0;
                                rd_en_r      <= 1'b1;
                                state_r      <= ST_RD1;
                            end
                            `RJL_LOAD_R_IMM: begin
                                wr_addr_r <= reg_addr(i_operand1, i_rp, 1'b1);
                                wr_data_r <= i_operand2;
                                wr_en_r   <= 1'b1;
                                state_r   <= ST_WR;
                            end
                            `RJL_LOAD_PTR_R: begin
                                rd_addr_r    <= reg_addr(i_operand1, i_rp,
                                                         1'b1);
                                src_r        <= reg_addr(i_operand2, i_rp,
                                                         1'b1);
                                ptr_to_dst_r <= 1'b1;
                                rd_en_r      <= 1'b1;
                                state_r      <= ST_RD1;
                            end
                            `RJL_LOAD_R_IDX: begin
                                dst_r        <= wreg(i_operand1[7:4], i_rp);
                                rd_addr_r    <= wreg(i_operand1[3:0], i_rp);
                                base_r       <= i_operand2;
                                ptr_to_dst_r <= 1'b0;
                                rd_en_r      <= 1'b1;
                                state_r      <= ST_RD1;
                            end
                            `RJL_LOAD_IDX_R: begin
                                src_r        <= wreg(i_operand1[7:4], i_rp);
                                rd_addr_r    <= wreg(i_operand1[3:0], i_rp);
                                base_r       <= i_operand2;
                                ptr_to_dst_r <= 1'b1;
                                rd_en_r      <= 1'b1;
                                state_r      <= ST_RD1;
                            end
                            default: begin
                                busy_r   <= 1'b0;
                                done_r   <= 1'b1;
                                bad_op_r <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_RD1: begin
                    state_r <= ST_G1;
                end
                ST_G1: begin
                    // pointer or index value is on the read data now
                    rd_en_r <= 1'b1;
                    state_r <= ST_RD2;
                    if (ptr_to_dst_r) begin
                        dst_r     <= eff_addr;
                        rd_addr_r <= src_r;
                    end else begin
                        rd_addr_r <= eff_addr;
                    end
                end
                ST_RD2: begin
                    state_r <= ST_G2;
                end
                ST_G2: begin
                    // source is only read, and no flag output exists
                    wr_addr_r <= dst_r;
                    wr_data_r <= i_rf_rd_data;
                    wr_en_r   <= 1'b1;
                    state_r   <= ST_WR;
                end
                ST_WR: begin
                    if (wr_addr_r == `RJL_INT_MASK_ADDR) begin
                        int_mask_r <= wr_data_r;
                    end
                    busy_r  <= 1'b0;
                    done_r  <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: begin
                    busy_r  <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_busy         = busy_r;
    assign o_done         = done_r;
    assign o_bad_op       = bad_op_r;
    assign o_pc_load      = pc_load_r;
    assign o_pc_value     = pc_value_r;
    assign o_branch_taken = taken_r;
    assign o_rf_rd_en     = rd_en_r;
    assign o_rf_rd_addr   = rd_addr_r;
    assign o_rf_wr_en     = wr_en_r;
    assign o_rf_wr_addr   = wr_addr_r;
    assign o_rf_wr_data   = wr_data_r;
    assign o_int_mask     = int_mask_r;

endmodule // rjl_exec

// >>> bench/rjl_rf_model.sv
// register file and fetch side partner with a one-cycle registered read
`timescale 1ns/100ps
module rjl_rf_model (
    input  wire       i_ref_clk,
    input  wire       i_rd_en,
    input  wire [7:0] i_rd_addr,
    input  wire       i_wr_en,
    input  wire [7:0] i_wr_addr,
    input  wire [7:0] i_wr_data,
    output reg  [7:0] o_rd_data
);
    reg [7:0] mem [0:255];
    initial o_rd_data = 8'h00;
    // outside the read cycle the data flips so a stale value never matches
    always @(posedge i_ref_clk) begin
        if (i_rd_en)
            o_rd_data <= mem[i_rd_addr];
        else
            o_rd_data <= ~o_rd_data;
        if (i_wr_en)
            mem[i_wr_addr] <= i_wr_data;
    end
endmodule // rjl_rf_model

// >>> bench/rjl_exec_checker.sv
// timing and result assertions on the execution unit ports
`timescale 1ns/100ps
module rjl_exec_checker (
    input wire        i_ref_clk,
    input wire        i_nrst,
    input wire        i_instr_valid,
    input wire [7:0]  i_opcode,
    input wire [7:0]  i_operand1,
    input wire [15:0] i_pc_next,
    input wire        o_busy,
    input wire        o_done,
    input wire        o_bad_op,
    input wire        o_pc_load,
    input wire [15:0] o_pc_value,
    input wire        o_branch_taken,
    input wire        o_rf_rd_en,
    input wire        o_rf_wr_en,
    input wire [7:0]  o_rf_wr_addr,
    input wire [7:0]  o_rf_wr_data,
    input wire [7:0]  o_int_mask
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    wire tk = i_instr_valid && !o_busy;
    wire br = tk && (i_opcode[3:0] == 4'hB);
    wire known_load = (i_opcode == 8'hE4) || (i_opcode == 8'hE5) ||
              (i_opcode == 8'hE6) || (i_opcode == 8'hF5) ||
              (i_opcode == 8'hC7) || (i_opcode == 8'hD7);
    sequence s_reg_load;
        o_busy [*3] ##1 (o_done && !o_busy);
    endsequence
    sequence s_imm_load;
        (o_busy && o_rf_wr_en) ##1 (o_done && !o_busy);
    endsequence
    a_branch_answer: assert property (br |=> o_pc_load && o_done)
        else $error("branch gave no pc load");
    a_taken_target: assert property (br && i_opcode[7:4] == 4'h8 |=>
        o_branch_taken && o_pc_value == $past(i_pc_next) +
        {{8{$past(i_operand1[7])}}, $past(i_operand1)})
        else $error("always branch target wrong");
    a_never_falls: assert property (br && i_opcode[7:4] == 4'h0 |=>
        !o_branch_taken && o_pc_value == $past(i_pc_next))
        else $error("never branch moved the pc");
    a_reg_load: assert property (tk && i_opcode == 8'hE4 |=>
        s_reg_load)
        else $error("register load timing wrong");
    a_imm_load: assert property (tk && i_opcode == 8'hE6 |=>
        s_imm_load)
        else $error("immediate load timing wrong");
    a_index_len: assert property (tk && i_opcode == 8'hD7 |=>
        o_busy [*5] ##1 o_done)
        else $error("indexed load timing wrong");
    a_bad_opcode: assert property (tk && !known_load &&
        i_opcode[3:0] != 4'hB |=>
        o_bad_op && o_done && !o_pc_load && !o_rf_wr_en)
        else $error("unknown opcode not flagged");
    a_mask_update: assert property (o_rf_wr_en &&
        o_rf_wr_addr == 8'hFB |=> o_int_mask == $past(o_rf_wr_data))
        else $error("interrupt mask not updated");
    a_read_pulse: assert property (o_rf_rd_en |=> !o_rf_rd_en)
        else $error("read strobe longer than a cycle");
endmodule // rjl_exec_checker

// >>> bench/testbench.sv
// self-checking bench for the relative branch and load unit
`timescale 1ns/100ps
module testbench;
    reg         i_ref_clk = 1'b0;
    reg         i_nrst = 1'b0;
    reg         i_instr_valid = 1'b0;
    reg  [7:0]  i_opcode = 8'h00;
    reg  [7:0]  i_operand1 = 8'h00;
    reg  [7:0]  i_operand2 = 8'h00;
    reg  [15:0] i_pc_next = 16'h0000;
    reg  [3:0]  flags = 4'h0;
    reg  [7:0]  i_rp = 8'h10;
    wire [7:0]  rd_data, rd_addr, wr_addr, wr_data, o_int_mask;
    wire [15:0] o_pc_value;
    wire        o_busy, o_done, o_bad_op, o_pc_load, o_branch_taken;
    wire        rd_en, wr_en;
    integer     err_total, num_checks, k;
    integer     seed = 32'hD63EBBF7;
    reg  [15:0] wr_q[$];
    always #5 i_ref_clk = ~i_ref_clk;
    rjl_exec rjl_exec_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_instr_valid(i_instr_valid), .i_opcode(i_opcode),
        .i_operand1(i_operand1), .i_operand2(i_operand2),
        .i_pc_next(i_pc_next), .i_flag_c(flags[3]), .i_flag_z(flags[2]),
        .i_flag_s(flags[1]), .i_flag_v(flags[0]), .i_rp(i_rp),
        .i_rf_rd_data(rd_data), .o_busy(o_busy), .o_done(o_done),
        .o_bad_op(o_bad_op), .o_pc_load(o_pc_load),
        .o_pc_value(o_pc_value), .o_branch_taken(o_branch_taken),
        .o_rf_rd_en(rd_en), .o_rf_rd_addr(rd_addr), .o_rf_wr_en(wr_en),
        .o_rf_wr_addr(wr_addr), .o_rf_wr_data(wr_data),
        .o_int_mask(o_int_mask));
    rjl_rf_model rjl_rf_model_inst (.i_ref_clk(i_ref_clk), .i_rd_en(rd_en),
        .i_rd_addr(rd_addr), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
        .i_wr_data(wr_data), .o_rd_data(rd_data));
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: %h vs %h", $time, seen, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            if (err_total == 0 && num_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // every write strobe must carry the next expected load result
    always @(negedge i_ref_clk) begin
        if (wr_en === 1'b1) begin
            if (wr_q.size() > 0)
                chk({wr_addr, wr_data}, wr_q.pop_front());
            else
                chk(wr_en, 1'b0);
        end
    end
    function [7:0] m(input [7:0] a);
        m = rjl_rf_model_inst.mem[a];
    endfunction
    function [7:0] ea(input [7:0] b);
        ea = (b[7:4] == 4'hE) ? {i_rp[7:4], b[3:0]} : b;
    endfunction
    function cond(input [3:0] c);
        reg r;
        begin
            case (c[2:0])
                3'h0: r = 1'b0;
                3'h1: r = flags[1] ^ flags[0];
                3'h2: r = flags[2] | (flags[1] ^ flags[0]);
                3'h3: r = flags[3] | flags[2];
                3'h4: r = flags[0];
                3'h5: r = flags[1];
                3'h6: r = flags[2];
                default: r = flags[3];
            endcase
            cond = r ^ c[3];
        end
    endfunction
    // the unit is idle again by the time the previous done was seen
    task issue(input [7:0] op, input [7:0] a, input [7:0] b);
        integer n;
        begin
            @(posedge i_ref_clk);
            #1 {i_opcode, i_operand1, i_operand2} = {op, a, b};
            i_instr_valid = 1'b1;
            @(posedge i_ref_clk);
            #1 i_instr_valid = 1'b0;
            n = 0;
            while (o_done !== 1'b1 && n < 20) begin
                @(posedge i_ref_clk);
                #1 n = n + 1;
            end
        end
    endtask
    task br(input [3:0] cc, input [7:0] d);
        reg t;
        reg [15:0] e;
        begin
            i_pc_next = $random(seed);
            flags = $random(seed);
            t = cond(cc);
            e = t ? i_pc_next + {{8{d[7]}}, d} : i_pc_next;
            issue({cc, 4'hB}, d, 8'h00);
            chk(o_pc_load, 1);
            chk(o_branch_taken, t);
            chk(o_pc_value, e);
        end
    endtask
    task run_load(input [7:0] op, input [7:0] a, input [7:0] b);
        reg [7:0] ad, dt, ix;
        begin
            ix = m({i_rp[7:4], a[3:0]});
            case (op)
                8'hE4: {ad, dt} = {ea(a), m(ea(b))};
                8'hE5: {ad, dt} = {a, m(m(ea(b)))};
                8'hE6: {ad, dt} = {ea(a), b};
                8'hF5: {ad, dt} = {m(ea(a)), m(ea(b))};
                8'hC7: {ad, dt} = {i_rp[7:4], a[7:4], m(b + ix)};
                default: {ad, dt} = {b + ix, m({i_rp[7:4], a[7:4]})};
            endcase
            wr_q.push_back({ad, dt});
            issue(op, a, b);
            chk(o_done, 1);
            chk(wr_addr, ad);
            chk(wr_data, dt);
            if (ad == 8'hFB)
                chk(o_int_mask, dt);
            if (op == 8'hE4)
                chk(m(ea(b)), dt);
            chk(wr_q.size(), 0);
        end
    endtask
    initial begin
        #100000 err_total = err_total + 1;
        wrap_up;
    end
    initial begin
        err_total = 0;
        num_checks = 0;
        for (k = 0; k < 256; k = k + 1)
            rjl_rf_model_inst.mem[k] = $random(seed);
        rjl_rf_model_inst.mem[8'h10] = 8'h0B;
        rjl_rf_model_inst.mem[8'h1A] = 8'h83;
        repeat (8) @(posedge i_ref_clk);
        #1 i_nrst = 1'b1;
        chk(o_int_mask, 8'h00);
        // every condition with both range ends and random distances
        for (k = 0; k < 48; k = k + 1)
            br(k, k < 16 ? 8'h7F : k < 32 ? 8'h80 : $random(seed));
        run_load(8'hD7, 8'hA0, 8'hF0);
        run_load(8'hE4, 8'hE3, 8'hE7);
        run_load(8'hE4, 8'h20, 8'h30);
        run_load(8'hE5, 8'hE3, 8'hE2);
        run_load(8'hE6, 8'hE5, $random(seed));
        run_load(8'hF5, 8'hE4, 8'hE6);
        run_load(8'hC7, 8'h52, 8'h40);
        issue(8'h00, 8'h00, 8'h00);
        chk(o_bad_op, 1);
        // mid-run reset, driven on the same offset as all other inputs
        @(posedge i_ref_clk);
        #1 i_nrst = 1'b0;
        @(posedge i_ref_clk);
        #1 chk(o_int_mask, 8'h00);
        chk(o_pc_value, 16'h0000);
        i_nrst = 1'b1;
        i_rp = 8'h30;
        run_load(8'hE4, 8'hE1, 8'hE2);
        br(4'h8, 8'hF0);
        wrap_up;
    end
endmodule // testbench
bind rjl_exec rjl_exec_checker rjl_exec_checker_inst (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_instr_valid(i_instr_valid),
    .i_opcode(i_opcode), .i_operand1(i_operand1), .i_pc_next(i_pc_next),
    .o_busy(o_busy), .o_done(o_done), .o_bad_op(o_bad_op),
    .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
    .o_branch_taken(o_branch_taken), .o_rf_rd_en(o_rf_rd_en),
    .o_rf_wr_en(o_rf_wr_en), .o_rf_wr_addr(o_rf_wr_addr),
    .o_rf_wr_data(o_rf_wr_data), .o_int_mask(o_int_mask));
